// [logic/dcr_consts.svh]
// Constants of the second device-control register block: indices, field
// positions, reset values and timing counts. Assumes a 100 ns system clock.
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define DCR_CLK_PERIOD_NS 100

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DCR_IDX_CTRL2 8'h25
`define DCR_IDX_IRQ_STAT 8'h30
`define DCR_IDX_IRQ_MASK 8'h31
`define DCR_IDX_STATE 8'h32

// ----------------------------------------------------------------------
// Field positions of device_control_two
// ----------------------------------------------------------------------
`define DCR_B_SLEEP_EN 7
`define DCR_B_IRQ_PUSH_PULL 6
`define DCR_B_SLOT_HI 5
`define DCR_B_SLOT_LO 4
`define DCR_B_SLEEP_INPUT_POLARITY 3
`define DCR_B_HOLD_OFF 2
`define DCR_B_HOLD_OFF_DEF 1
`define DCR_B_IRQ_POL 0

// ----------------------------------------------------------------------
// Interrupt status and mask layout
// ----------------------------------------------------------------------
`define DCR_EV_W 3
`define DCR_EV_HOLD 0
`define DCR_EV_SLEEP 1
`define DCR_EV_OFF 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DCR_CTRL2_RESET 8'h70
`define DCR_MASK_RESET 3'h0
`define DCR_STAT_RESET 3'h0

// ----------------------------------------------------------------------
// Times as printed and derived cycle counts (least times round up)
// ----------------------------------------------------------------------
`define DCR_SLOT0_US 30
`define DCR_SLOT1_US 200
`define DCR_SLOT2_US 500
`define DCR_SLOT3_MS 2
`define DCR_HOLD_IRQ_S 4
`define DCR_HOLD_OFF_S 5
`define DCR_US_CYC(t) (((t) * 1000 + `DCR_CLK_PERIOD_NS - 1) / `DCR_CLK_PERIOD_NS)
`define DCR_SLOT0_CYC `DCR_US_CYC(`DCR_SLOT0_US)
`define DCR_SLOT1_CYC `DCR_US_CYC(`DCR_SLOT1_US)
`define DCR_SLOT2_CYC `DCR_US_CYC(`DCR_SLOT2_US)
`define DCR_SLOT3_CYC `DCR_US_CYC(`DCR_SLOT3_MS * 1000)
`define DCR_S_CYC(t) (32'((64'd1000000000 * (t)) / `DCR_CLK_PERIOD_NS))
`define DCR_HOLD_IRQ_CYC `DCR_S_CYC(`DCR_HOLD_IRQ_S)
`define DCR_HOLD_OFF_CYC `DCR_S_CYC(`DCR_HOLD_OFF_S)

`endif

// [logic/dcr_device_control_two.sv]
// Second device-control register with sleep input, interrupt pin,
// slot timing and power-button long-press shutdown.
// Assumes a classic Wishbone master and pins synchronous to CLOCK.
`timescale 1ns/100ps
`include "dcr_consts.svh"
module dcr_device_control_two #(
  parameter int SLOT2_CYC = `DCR_SLOT2_CYC,
  parameter int SLOT3_CYC = `DCR_SLOT3_CYC,
  parameter int HOLD_IRQ_CYC = `DCR_HOLD_IRQ_CYC,
  parameter int HOLD_OFF_CYC = `DCR_HOLD_OFF_CYC
) (
  input wire logic CLOCK, // 10 MHz system clock
  input wire logic SYS_RST, // Synchronous power-on reset
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Strobe
  input wire logic WB_WE_I, // Write enable
  input wire logic [9:2] WB_ADR_I, // Word index
  input wire logic [3:0] WB_SEL_I, // Byte lanes
  input wire dcr_pkg::dcr_word_t WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Acknowledge
  input wire logic SLEEP_IN, // Sleep request pin
  input wire logic POWER_BUTTON_N, // Power button, low pressed
  input wire logic RESET_INPUT_MODE, // Button pin used as reset input
  output logic SLEEP_REQ, // Qualified sleep request
  output logic DEVICE_OFF, // Device in OFF state
  output logic REG_RELOAD, // Pulse: registers reloaded
  output logic SLOT_TICK, // Pulse: sequencing slot boundary
  output logic INT_O, // Level interrupt, active high
  output logic IRQ_PIN_O, // Interrupt pin output value
  output logic IRQ_PIN_OE // Interrupt pin drive enable
);
  import dcr_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [`DCR_EV_W-1:0] mask_r;
  logic [`DCR_EV_W-1:0] stat_r;
  logic [`DCR_EV_W-1:0] stat_nxt;
  logic [`DCR_EV_W-1:0] ev_set;
  logic [`DCR_EV_W-1:0] ev_clr;
  dcr_state_t state_r;
  dcr_state_t state_nxt;
  logic ack_r;
  logic [31:0] dat_r;
  logic sleep_req_r;
  logic sleep_req_nxt;
  logic off_r;
  logic reload_r;
  logic reload_nxt;
  logic int_r;
  logic pin_o_r;
  logic pin_oe_r;
  logic bus_req;
  logic bus_wr;
  logic armed;
  logic irq_any;
  logic pin_lvl;
  logic off_enter;

  dcr_timer_if tmr ();

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  dcr_slot_timer #(
    .SLOT2_CYC(SLOT2_CYC),
    .SLOT3_CYC(SLOT3_CYC)
  ) u_slot (
    .clk(CLOCK),
    .rst(SYS_RST),
    .tmr(tmr.slot)
  );

  dcr_hold_timer #(
    .HOLD_IRQ_CYC(HOLD_IRQ_CYC),
    .HOLD_OFF_CYC(HOLD_OFF_CYC)
  ) u_hold (
    .clk(CLOCK),
    .rst(SYS_RST),
    .tmr(tmr.hold)
  );

  assign tmr.slot_sel = ctrl_r[`DCR_B_SLOT_HI:`DCR_B_SLOT_LO];
  assign tmr.hold_run = (state_r == DCR_HOLD) || (state_r == DCR_HOLD_DEF);

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  // One request per ack: the ack cycle itself is not a new request
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign bus_wr = bus_req && WB_WE_I && WB_SEL_I[0];

  function automatic logic wr_hit(input dcr_index_t idx);
    wr_hit = bus_wr && (WB_ADR_I == idx);
  endfunction

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // Unmapped indices answer with zero data, never stall
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      dat_r <= 32'h00000000;
    end else if (bus_req) begin
      unique case (WB_ADR_I)
        `DCR_IDX_CTRL2: dat_r <= {24'h000000, ctrl_r};
        `DCR_IDX_IRQ_STAT: dat_r <= {29'h00000000, stat_r};
        `DCR_IDX_IRQ_MASK: dat_r <= {29'h00000000, mask_r};
        `DCR_IDX_STATE: dat_r <= {24'h000000, POWER_BUTTON_N, sleep_req_r, off_r, state_r};
        default: dat_r <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // power-on defaults
  // reload on defaults long-press off
  // Reload outranks a write in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || reload_nxt) begin
      ctrl_r <= `DCR_CTRL2_RESET;
    end else if (wr_hit(`DCR_IDX_CTRL2)) begin
      ctrl_r <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || reload_nxt) begin
      mask_r <= `DCR_MASK_RESET;
    end else if (wr_hit(`DCR_IDX_IRQ_MASK)) begin
      mask_r <= WB_DAT_I[`DCR_EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Sleep input
  // ----------------------------------------------------------------------
  // ignore pin when disabled
  assign sleep_req_nxt = ctrl_r[`DCR_B_SLEEP_EN] && (SLEEP_IN == ctrl_r[`DCR_B_SLEEP_INPUT_POLARITY]);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sleep_req_r <= 1'b0;
    end else begin
      sleep_req_r <= sleep_req_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Long-press state machine
  // ----------------------------------------------------------------------
  // reset-input variant disarms
  assign armed = !RESET_INPUT_MODE &&
                 (ctrl_r[`DCR_B_HOLD_OFF] || ctrl_r[`DCR_B_HOLD_OFF_DEF]);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DCR_IDLE: begin
        if (armed && !POWER_BUTTON_N) begin
          state_nxt = DCR_HOLD;
        end
      end
      DCR_HOLD: begin
        if (!armed || POWER_BUTTON_N) begin
          state_nxt = DCR_IDLE;
        end else if (tmr.hold_irq_hit) begin
          state_nxt = ctrl_r[`DCR_B_HOLD_OFF_DEF] ? DCR_HOLD_DEF : DCR_OFF;
        end
      end
      DCR_HOLD_DEF: begin
        if (RESET_INPUT_MODE || POWER_BUTTON_N) begin
          state_nxt = DCR_IDLE;
        end else if (!ctrl_r[`DCR_B_HOLD_OFF_DEF]) begin
          state_nxt = ctrl_r[`DCR_B_HOLD_OFF] ? DCR_OFF : DCR_IDLE;
        end else if (tmr.hold_off_hit) begin
          state_nxt = DCR_OFF;
        end
      end
      DCR_OFF: begin
        // Wait for release so the same press does not restart
        if (POWER_BUTTON_N) begin
          state_nxt = DCR_OFF_REL;
        end
      end
      DCR_OFF_REL: begin
        if (!POWER_BUTTON_N) begin
          state_nxt = DCR_IDLE;
        end
      end
      default: state_nxt = DCR_IDLE;
    endcase
  end

  assign off_enter = (state_nxt == DCR_OFF) && (state_r != DCR_OFF);
  assign reload_nxt = (state_r == DCR_HOLD_DEF) && (state_nxt == DCR_OFF) &&
                      ctrl_r[`DCR_B_HOLD_OFF_DEF];

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_r <= DCR_IDLE;
      off_r <= 1'b0;
      reload_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      off_r <= (state_nxt == DCR_OFF) || (state_nxt == DCR_OFF_REL);
      reload_r <= reload_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and pin
  // ----------------------------------------------------------------------
  // interrupt at four seconds
  assign ev_set[`DCR_EV_HOLD] = (state_r == DCR_HOLD) && tmr.hold_irq_hit && armed &&
                                !POWER_BUTTON_N;
  assign ev_set[`DCR_EV_SLEEP] = sleep_req_nxt != sleep_req_r;
  assign ev_set[`DCR_EV_OFF] = off_enter;
  assign ev_clr = wr_hit(`DCR_IDX_IRQ_STAT) ? WB_DAT_I[`DCR_EV_W-1:0] : `DCR_STAT_RESET;
  // A new event in the clearing cycle survives the clear
  assign stat_nxt = (stat_r & ~ev_clr) | ev_set;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      stat_r <= `DCR_STAT_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  assign irq_any = |(stat_r & mask_r);
  assign pin_lvl = ctrl_r[`DCR_B_IRQ_POL] ? irq_any : !irq_any;

  // open drain or push-pull
  // Open drain can only pull low; a high level needs the external pull-up
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      int_r <= 1'b0;
      pin_o_r <= 1'b1;
      pin_oe_r <= 1'b1;
    end else begin
      int_r <= irq_any;
      pin_o_r <= ctrl_r[`DCR_B_IRQ_PUSH_PULL] ? pin_lvl : 1'b0;
      pin_oe_r <= ctrl_r[`DCR_B_IRQ_PUSH_PULL] || !pin_lvl;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
  assign SLEEP_REQ = sleep_req_r;
  assign DEVICE_OFF = off_r;
  assign REG_RELOAD = reload_r;
  assign SLOT_TICK = tmr.slot_tick;
  assign INT_O = int_r;
  assign IRQ_PIN_O = pin_o_r;
  assign IRQ_PIN_OE = pin_oe_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sleep_ignore_a: assert property (
    !ctrl_r[`DCR_B_SLEEP_EN] |=> !sleep_req_r)
    else $error("sleep request raised while input disabled");
  sleep_level_a: assert property (
    (ctrl_r[`DCR_B_SLEEP_EN] && SLEEP_IN == ctrl_r[`DCR_B_SLEEP_INPUT_POLARITY]) |=> sleep_req_r)
    else $error("sleep pin at asserted level not honoured");
  sleep_polarity_a: assert property (
    (ctrl_r[`DCR_B_SLEEP_EN] && SLEEP_IN != ctrl_r[`DCR_B_SLEEP_INPUT_POLARITY]) |=> !sleep_req_r)
    else $error("sleep pin at idle level gave a request");
  drive_type_a: assert property (
    ($stable(ctrl_r) && !ctrl_r[`DCR_B_IRQ_PUSH_PULL])
      |-> (!pin_o_r && (pin_oe_r == (int_r != ctrl_r[`DCR_B_IRQ_POL]))))
    else $error("open-drain pin driven high or wrong enable");
  pin_polarity_a: assert property (
    ($stable(ctrl_r) && ctrl_r[`DCR_B_IRQ_PUSH_PULL])
      |-> (pin_oe_r && pin_o_r == (int_r == ctrl_r[`DCR_B_IRQ_POL])))
    else $error("push-pull pin level does not follow polarity");
  plain_off_a: assert property (
    (state_r == DCR_HOLD && tmr.hold_irq_hit && armed && !POWER_BUTTON_N &&
     !ctrl_r[`DCR_B_HOLD_OFF_DEF])
      |=> (off_r && stat_r[`DCR_EV_HOLD] && !reload_r))
    else $error("plain long press did not go off with interrupt");
  hold_irq_a: assert property (
    (state_r == DCR_HOLD && tmr.hold_irq_hit && armed && !POWER_BUTTON_N)
      |=> stat_r[`DCR_EV_HOLD])
    else $error("long press interrupt not raised");
  defaults_off_a: assert property (
    (state_r == DCR_HOLD_DEF && tmr.hold_off_hit && !POWER_BUTTON_N &&
     !RESET_INPUT_MODE && ctrl_r[`DCR_B_HOLD_OFF_DEF])
      |=> (off_r && reload_r && ctrl_r == `DCR_CTRL2_RESET) ##1 !reload_r)
    else $error("defaults long press did not reload and go off");
  hold_priority_a: assert property (
    (state_r == DCR_HOLD && tmr.hold_irq_hit && armed && !POWER_BUTTON_N &&
     ctrl_r[`DCR_B_HOLD_OFF_DEF]) |=> (state_r == DCR_HOLD_DEF && !off_r))
    else $error("defaults long press lost precedence");
  strap_ignore_a: assert property (
    (RESET_INPUT_MODE && !off_r) |=> (state_r == DCR_IDLE && !tmr.hold_run))
    else $error("long press tracked in reset-input variant");
  por_reset_a: assert property (disable iff (1'b0)
    SYS_RST |=> (ctrl_r == `DCR_CTRL2_RESET && stat_r == `DCR_STAT_RESET && !WB_ACK_O))
    else $error("reset did not restore register");
  ack_pulse_a: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held beyond one cycle");
endmodule // dcr_device_control_two

// [logic/dcr_hold_timer.sv]
// Power-button long-press timer: pulses at the interrupt and off marks.
// Assumes hold_run stays high for the whole press being timed.
`timescale 1ns/100ps
`include "dcr_consts.svh"
module dcr_hold_timer #(
  parameter int HOLD_IRQ_CYC = `DCR_HOLD_IRQ_CYC,
  parameter int HOLD_OFF_CYC = `DCR_HOLD_OFF_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  dcr_timer_if.hold tmr // Run level and mark pulses
);
  import dcr_pkg::*;

  logic [25:0] cnt_r;

  // four and five second marks
  // Counter saturates so each mark pulses once per press
  always_ff @(posedge clk) begin
    if (rst || !tmr.hold_run) begin
      cnt_r <= 26'h0000000;
      tmr.hold_irq_hit <= 1'b0;
      tmr.hold_off_hit <= 1'b0;
    end else begin
      if (cnt_r != 26'(HOLD_OFF_CYC)) begin
        cnt_r <= cnt_r + 26'h0000001;
      end
      tmr.hold_irq_hit <= (cnt_r == 26'(HOLD_IRQ_CYC - 1));
      tmr.hold_off_hit <= (cnt_r == 26'(HOLD_OFF_CYC - 1));
    end
  end

  hold_start_a: assert property (@(posedge clk) disable iff (rst)
    $rose(tmr.hold_run) |=> !tmr.hold_irq_hit [*8])
    else $error("hold mark fired right after press start");
endmodule // dcr_hold_timer

// [logic/dcr_pkg.sv]
// Types shared by the second device-control register block.
// Assumes dcr_consts.svh for all numeric constants except the one-hot state codes.
package dcr_pkg;
  typedef logic [31:0] dcr_word_t;
  typedef logic [7:0] dcr_index_t;
  typedef enum logic [4:0] {
    DCR_IDLE = 5'h01,
    DCR_HOLD = 5'h02,
    DCR_HOLD_DEF = 5'h04,
    DCR_OFF = 5'h08,
    DCR_OFF_REL = 5'h10
  } dcr_state_t;
endpackage

// [logic/dcr_slot_timer.sv]
// Sequencing time-slot enable generator: one-cycle tick per slot.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "dcr_consts.svh"
module dcr_slot_timer #(
  parameter int SLOT2_CYC = `DCR_SLOT2_CYC,
  parameter int SLOT3_CYC = `DCR_SLOT3_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  dcr_timer_if.slot tmr // Slot select and tick
);
  import dcr_pkg::*;

  logic [14:0] cnt_r;
  logic [8:0] calm_r;

  function automatic logic [14:0] slot_len(input logic [1:0] sel);
    unique case (sel)
      2'b00: slot_len = 15'(`DCR_SLOT0_CYC);
      2'b01: slot_len = 15'(`DCR_SLOT1_CYC);
      2'b10: slot_len = 15'(SLOT2_CYC);
      2'b11: slot_len = 15'(SLOT3_CYC);
    endcase
  endfunction

  // slot length select
  // Compare with >= so a switch to a shorter slot ends the current one
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 15'h0000;
      tmr.slot_tick <= 1'b0;
    end else if (cnt_r >= slot_len(tmr.slot_sel) - 15'h0001) begin
      cnt_r <= 15'h0000;
      tmr.slot_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 15'h0001;
      tmr.slot_tick <= 1'b0;
    end
  end

  // Run of cycles with the 30 us slot held; a switch away may stretch a slot
  always_ff @(posedge clk) begin
    if (rst || tmr.slot_sel != 2'b00) begin
      calm_r <= 9'h000;
    end else if (calm_r != 9'h1FF) begin
      calm_r <= calm_r + 9'h001;
    end
  end

  slot_gap_a: assert property (@(posedge clk) disable iff (rst)
    (tmr.slot_tick && tmr.slot_sel == 2'b00) |=> !tmr.slot_tick [*8])
    else $error("slot tick repeated too soon");
  slot_period_a: assert property (@(posedge clk) disable iff (rst)
    (tmr.slot_tick && tmr.slot_sel == 2'b00)
      |-> ##300 (tmr.slot_tick || calm_r < 9'h12C))
    else $error("30 us slot not 300 cycles");
endmodule // dcr_slot_timer

// [logic/dcr_timer_if.sv]
// Carrier between the control core and its slot and hold timers.
// Assumes all three parties run on the same clock.
`timescale 1ns/100ps
interface dcr_timer_if;
  logic [1:0] slot_sel;
  logic slot_tick;
  logic hold_run;
  logic hold_irq_hit;
  logic hold_off_hit;
  modport ctrl (output slot_sel, output hold_run,
                input slot_tick, input hold_irq_hit, input hold_off_hit);
  modport slot (input slot_sel, output slot_tick);
  modport hold (input hold_run, output hold_irq_hit, output hold_off_hit);
endinterface

// [testbench/dcr_device_control_two_tb.sv]
// Self-checking bench of the second device-control register block.
// Assumes shortened hold counts, shortened slot 2 and 3 counts and the pin model at the far side.
`timescale 1ns/100ps
`include "dcr_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %0h exp %0h", $time, (a), (e)); end end
module dcr_device_control_two_tb;
  import dcr_pkg::*;
  localparam int HI = 40, HO = 60, S2 = 50, S3 = 80;
  localparam logic [7:0] A_CT = `DCR_IDX_CTRL2, A_ST = `DCR_IDX_IRQ_STAT;
  localparam logic [7:0] A_MK = `DCR_IDX_IRQ_MASK;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  dcr_word_t dat = 32'h0;
  logic press = 1'b0;
  logic slp = 1'b0;
  logic rim = 1'b0;
  wire logic [31:0] dat_o;
  wire logic ack, sreq, off, reload, tick, int_o, pin_o, pin_oe, btn_n, sleep_pin, irq_wire;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h7C7FFBB2;
  int slot_n[4] = '{`DCR_SLOT0_CYC, `DCR_SLOT1_CYC, S2, S3};
  logic [7:0] m_ctrl = 8'h70;
  logic [7:0] m_mask = 8'h00;
  logic [7:0] m_stat = 8'h00;

  dcr_device_control_two #(.SLOT2_CYC(S2), .SLOT3_CYC(S3), .HOLD_IRQ_CYC(HI),
    .HOLD_OFF_CYC(HO)) dcr_device_control_two_inst (.CLOCK(clock), .SYS_RST(sys_rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SLEEP_IN(sleep_pin),
    .POWER_BUTTON_N(btn_n), .RESET_INPUT_MODE(rim), .SLEEP_REQ(sreq), .DEVICE_OFF(off),
    .REG_RELOAD(reload), .SLOT_TICK(tick), .INT_O(int_o), .IRQ_PIN_O(pin_o),
    .IRQ_PIN_OE(pin_oe));
  dcr_pin_env dcr_pin_env_inst (.clk(clock), .press(press), .sleep_lvl(slp),
    .pin_o(pin_o), .pin_oe(pin_oe), .button_n(btn_n), .sleep_pin(sleep_pin),
    .irq_wire(irq_wire));

  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("ERROR %0t: run limit reached", $time);
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Bus and model tasks
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {8'($random(seed)), 16'h0000, d};
    do begin
      @(posedge clock);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) begin
      n_errors++;
      $display("ERROR %0t: no bus answer", $time);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    if (a == A_CT) m_ctrl = d;
    if (a == A_MK) m_mask = d & 8'h07;
    if (a == A_ST) m_stat = m_stat & ~d;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(q, {24'h0, e})
  endtask

  task automatic chk_pins();
    logic act;
    logic lvl;
    act = (m_stat & m_mask) != 8'h00;
    lvl = act ? m_ctrl[0] : ~m_ctrl[0];
    `CHK(int_o, act)
    `CHK(irq_wire, lvl)
    `CHK(pin_oe, m_ctrl[6] ? 1'b1 : ~lvl)
  endtask

  // Counts edges until a chosen output is high; bounded so a stuck line ends
  task automatic wait_hi(input int which, input int lim, output int n, output logic rl);
    n = 0;
    rl = 1'b0;
    do begin
      @(posedge clock);
      #1;
      n++;
      rl = rl | (reload === 1'b1);
    end while (!((which == 0 ? tick : which == 1 ? off : int_o) === 1'b1) && n < lim);
  endtask

  task automatic leave_off();
    press <= 1'b0;
    repeat (4) @(posedge clock);
    press <= 1'b1;
    repeat (3) @(posedge clock);
    press <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int m;
    logic rl;
    logic [7:0] v;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(A_CT, 8'h70);
    rd_chk(A_MK, 8'h00);
    rd_chk(A_ST, 8'h00);
    rd_chk(8'h77, 8'h00);
    rd_chk(`DCR_IDX_STATE, 8'h81);
    chk_pins();
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed)) & 8'h79;
      wr(A_CT, v);
      rd_chk(A_CT, v);
      chk_pins();
    end
    // Sleep enable clear: pin has no effect
    wr(A_CT, 8'h70);
    for (int l = 0; l < 2; l++) begin
      slp <= l[0];
      repeat (4) @(posedge clock);
      `CHK(sreq, 1'b0)
    end
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        wr(A_CT, 8'hF0 | 8'(p << 3));
        slp <= l[0];
        repeat (4) @(posedge clock);
        `CHK(sreq, 1'(l == p))
      end
    end
    wr(A_CT, 8'h70);
    repeat (4) @(posedge clock);
    rd_chk(A_ST, 8'h02);
    wr(A_ST, 8'h07);
    rd_chk(A_ST, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(A_CT, 8'h40 | 8'(k << 4));
      wait_hi(0, 3000, n, rl);
      wait_hi(0, 3000, n, rl);
      `CHK(n, slot_n[k])
    end
    // Plain long press, open drain, all events unmasked
    wr(A_MK, 8'h07);
    wr(A_CT, 8'h04);
    press <= 1'b1;
    @(posedge clock);
    wait_hi(1, HO + 20, n, rl);
    `CHK(n >= HI + 1 && n <= HI + 3, 1'b1)
    m_stat = 8'h05;
    repeat (3) @(posedge clock);
    rd_chk(A_ST, 8'h05);
    chk_pins();
    wr(A_ST, 8'h07);
    wr(A_CT, 8'h40);
    leave_off();
    `CHK(off, 1'b0)
    chk_pins();
    // Both hold bits: defaults variant must win
    wr(A_CT, 8'h46);
    press <= 1'b1;
    @(posedge clock);
    wait_hi(2, HO + 20, n, rl);
    `CHK(n >= HI + 1 && n <= HI + 4, 1'b1)
    `CHK(off, 1'b0)
    wait_hi(1, HO + 20, m, rl);
    `CHK(n + m >= HO + 1 && n + m <= HO + 3, 1'b1)
    `CHK(rl, 1'b1)
    m_ctrl = 8'h70;
    m_mask = 8'h00;
    m_stat = 8'h05;
    rd_chk(A_CT, 8'h70);
    rd_chk(A_MK, 8'h00);
    rd_chk(A_ST, 8'h05);
    wr(A_ST, 8'h07);
    leave_off();
    // Reset-input variant ignores both hold bits
    rim <= 1'b1;
    wr(A_MK, 8'h07);
    wr(A_CT, 8'h46);
    press <= 1'b1;
    repeat (HO + 20) @(posedge clock);
    `CHK(off, 1'b0)
    `CHK(int_o, 1'b0)
    press <= 1'b0;
    rim <= 1'b0;
    repeat (4) @(posedge clock);
    close_out();
  end
endmodule // dcr_device_control_two_tb

// [testbench/dcr_pin_env.sv]
// Far-side pin model: power button, sleep source, pulled-up irq wire.
// Assumes the bench requests levels and the lines follow after an edge.
`timescale 1ns/100ps
module dcr_pin_env (
  input wire logic clk, // System clock
  input wire logic press, // Request: hold button down
  input wire logic sleep_lvl, // Request: sleep pin level
  input wire logic pin_o, // Interrupt pin value
  input wire logic pin_oe, // Interrupt pin enable
  output logic button_n, // Button line, low pressed
  output logic sleep_pin, // Sleep request line
  output wire logic irq_wire // Resolved interrupt wire
);
  initial button_n = 1'b1;
  initial sleep_pin = 1'b0;
  // Lines move only just after an edge, like a switch sampled by the host
  always @(posedge clk) begin
    button_n <= ~press;
    sleep_pin <= sleep_lvl;
  end
  // Pull-up shows whenever the open-drain driver lets go
  assign irq_wire = pin_oe ? pin_o : 1'b1;
endmodule // dcr_pin_env
